// ### core/mms_core.sv
// Mode latch, address decode and interrupt sequencer
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "mms_defines.svh"
module mms_core #(
  parameter int BUS_DIV = `MMS_BUS_DIV
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic mode_pin_low_i,
  input wire logic mode_pin_mid_i,
  input wire logic mode_pin_high_i,
  input wire logic [4:0] port_two_pins_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire mms_pkg::mms_cpu_s cpu_i,
  input wire logic [15:0] cpu_addr_out_i,
  output mms_pkg::mms_tgt_e target_o,
  output logic external_page_select_o,
  output logic rom_sel_o,
  output logic ram_sel_o,
  output logic reg_sel_o,
  output logic ext_sel_o,
  output logic mux_bus_o,
  output logic bus_phase_o,
  output logic address_latch_strobe_o,
  output logic [7:0] port_four_out_o,
  output logic [7:0] port_four_oe_o,
  input wire logic nmi_n_i,
  input wire logic first_maskable_request_n_i,
  input wire logic port_three_input_strobe_flag_i,
  input wire mms_pkg::mms_second_maskable_request_s second_maskable_request_flags_i,
  input wire logic software_trap_i,
  input wire logic instr_done_i,
  input wire logic mask_bit_i,
  output logic second_maskable_request_o,
  output logic irq_busy_o,
  output logic stack_push_o,
  output logic [2:0] stack_index_o,
  output logic set_mask_o,
  output logic vector_load_o,
  output logic [15:0] vector_addr_o,
  output logic vector_external_o
);
  import mms_pkg::*;

  typedef struct packed {
    logic in_reset;
    logic [2:0] mode;
    logic [7:0] ddr_four;
    logic [3:0] src_en;
    logic nmi_prev;
    logic nmi_pend;
    logic [1:0] div;
    logic [1:0] ext_vec_cnt;
    mms_seq_e seq;
    logic [2:0] stk;
    logic [15:0] vec;
    logic vload;
    logic [7:0] rdata;
  } mms_state_s;

  mms_state_s st_r;
  mms_state_s st_nxt;
  logic [15:0] a;
  logic in_reg;
  logic nmux;
  logic p34_ext;
  logic p3_ext;
  logic dead;
  logic first_maskable_request_req;
  logic second_maskable_request_req;
  logic [15:0] pick_vec;
  logic take;
  logic phase_end;

  // Mode classes
  assign nmux = (st_r.mode == 3'd5);
  assign a = cpu_i.addr;
  assign in_reg = (a < `MMS_REG_AREA_TOP);
  assign p34_ext = (st_r.mode <= 3'd3) && (a[7:0] == `MMS_OFS_DDR_THREE
    || a[7:0] == `MMS_OFS_DDR_FOUR || a[7:0] == `MMS_OFS_DATA_THREE
    || a[7:0] == `MMS_OFS_DATA_FOUR || a[7:0] == `MMS_OFS_CSR_THREE);
  assign p3_ext = (st_r.mode == 3'd5 || st_r.mode == 3'd6) && (a[7:0] == `MMS_OFS_DDR_THREE
    || a[7:0] == `MMS_OFS_DATA_THREE || a[7:0] == `MMS_OFS_CSR_THREE);
  assign dead = nmux && p3_ext;

  // Address decode, one target per access
  always_comb begin
    target_o = MMS_T_NONE;
    if (cpu_i.rd || cpu_i.wr) begin
      if (in_reg) begin
        if (dead) target_o = MMS_T_NONE;
        else if (p34_ext || p3_ext) target_o = MMS_T_EXT;
        else target_o = MMS_T_REG;
      end else if (st_r.mode == 3'd4 && a[7]) begin
        target_o = MMS_T_RAM;
      end else if (st_r.mode != 3'd3 && st_r.mode != 3'd4
                   && a >= `MMS_RAM_BASE && a <= `MMS_RAM_TOP) begin
        target_o = MMS_T_RAM;
      end else if (st_r.mode == 3'd0 && a >= `MMS_VEC_RESET && st_r.ext_vec_cnt != 2'd0) begin
        // Checked ahead of ROM so the early reset vector really goes outside
        target_o = MMS_T_EXT;
      end else if ((st_r.mode == 3'd0 || st_r.mode == 3'd1 || st_r.mode >= 3'd5)
                   && st_r.mode != 3'd4 && a >= `MMS_ROM_BASE) begin
        target_o = MMS_T_ROM;
      end else if (st_r.mode == 3'd7 || st_r.mode == 3'd4) begin
        target_o = MMS_T_NONE;
      end else if (nmux) begin
        target_o = (a >= `MMS_PAGE_BASE && a <= `MMS_PAGE_TOP) ? MMS_T_EXT : MMS_T_NONE;
      end else begin
        target_o = MMS_T_EXT;
      end
    end
  end

  // Selects follow the single decoded target, so two drivers can never meet
  assign rom_sel_o = (target_o == MMS_T_ROM);
  assign ram_sel_o = (target_o == MMS_T_RAM);
  assign reg_sel_o = (target_o == MMS_T_REG);
  assign ext_sel_o = (target_o == MMS_T_EXT);
  assign external_page_select_o = nmux && ext_sel_o && !in_reg;
  assign mux_bus_o = !nmux && st_r.mode != 3'd7 && st_r.mode != 3'd4;
  assign bus_phase_o = st_r.div[1];
  assign address_latch_strobe_o = mux_bus_o && (st_r.div == 2'd0);
  assign phase_end = (st_r.div == 2'(BUS_DIV - 1));

  // Port four: address where enabled, ones while still inputs
  always_comb begin
    port_four_out_o = 8'hff;
    port_four_oe_o = 8'h00;
    if (nmux) begin
      port_four_oe_o = st_r.ddr_four;
      port_four_out_o = cpu_addr_out_i[7:0] | ~st_r.ddr_four;
    end else if (st_r.mode == 3'd6) begin
      port_four_oe_o = st_r.ddr_four;
      port_four_out_o = cpu_addr_out_i[15:8] | ~st_r.ddr_four;
    end else if (mux_bus_o) begin
      port_four_oe_o = 8'hff;
      port_four_out_o = cpu_addr_out_i[15:8];
    end
  end

  // Interrupt request lines and vector choice
  assign second_maskable_request_o = |(second_maskable_request_flags_i & st_r.src_en);
  assign first_maskable_request_req = (!first_maskable_request_n_i || port_three_input_strobe_flag_i)
    && !mask_bit_i;
  assign second_maskable_request_req = second_maskable_request_o && !mask_bit_i;
  always_comb begin
    pick_vec = `MMS_VEC_SCI;
    if (st_r.nmi_pend) pick_vec = `MMS_VEC_NMI;
    else if (software_trap_i) pick_vec = `MMS_VEC_SWI;
    else if (first_maskable_request_req) pick_vec = `MMS_VEC_FIRST_MASKABLE_REQUEST;
    else if (second_maskable_request_flags_i.capture_event_flag && st_r.src_en[3]) pick_vec = `MMS_VEC_ICF;
    else if (second_maskable_request_flags_i.compare_match_flag && st_r.src_en[2]) pick_vec = `MMS_VEC_OCF;
    else if (second_maskable_request_flags_i.counter_overflow_flag && st_r.src_en[1]) pick_vec = `MMS_VEC_TOF;
    else pick_vec = `MMS_VEC_SCI;
  end
  assign take = instr_done_i && st_r.seq == MMS_IDLE && !st_r.in_reset
    && (st_r.nmi_pend || software_trap_i || first_maskable_request_req || second_maskable_request_req);

  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.in_reset = 1'b0;
    st_nxt.vload = 1'b0;
    st_nxt.nmi_prev = nmi_n_i;
    st_nxt.div = st_r.div + 2'd1;
    if (st_r.in_reset) begin
      st_nxt.mode = {mode_pin_high_i, mode_pin_mid_i, mode_pin_low_i};
      st_nxt.ext_vec_cnt = 2'(`MMS_EXT_VEC_CYCLES);
      st_nxt.vec = `MMS_VEC_RESET;
      st_nxt.vload = 1'b1;
      st_nxt.div = 2'd0;
    end else if (phase_end && st_r.ext_vec_cnt != 2'd0) begin
      st_nxt.ext_vec_cnt = st_r.ext_vec_cnt - 2'd1;
    end
    // Falling edge of the non-maskable line latches a request; set beats clear
    if (st_r.nmi_prev && !nmi_n_i) st_nxt.nmi_pend = 1'b1;
    else if (take && st_r.nmi_pend) st_nxt.nmi_pend = 1'b0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `MMS_OFS_PORT_TWO_DATA: begin
          if (st_r.mode == 3'd4 && reg_wdata_i[`MMS_MODE_BIT_POS]) st_nxt.mode = 3'd5;
        end
        `MMS_OFS_DDR_FOUR: st_nxt.ddr_four = reg_wdata_i;
        `MMS_OFS_IRQ_CTRL: st_nxt.src_en = reg_wdata_i[3:0];
        default: ;
      endcase
    end
    case (st_r.seq)
      MMS_IDLE: begin
        if (take) begin
          st_nxt.seq = MMS_STACK;
          st_nxt.stk = 3'd0;
          st_nxt.vec = pick_vec;
        end
      end
      MMS_STACK: begin
        st_nxt.stk = st_r.stk + 3'd1;
        if (st_r.stk == `MMS_STACK_BYTES - 3'd1) st_nxt.seq = MMS_FETCH;
      end
      MMS_FETCH: begin
        st_nxt.vload = 1'b1;
        st_nxt.seq = MMS_IDLE;
      end
      default: st_nxt.seq = MMS_IDLE;
    endcase
    st_nxt.rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `MMS_OFS_PORT_TWO_DATA: st_nxt.rdata = {st_r.mode, port_two_pins_i};
        `MMS_OFS_DDR_FOUR: st_nxt.rdata = st_r.ddr_four;
        `MMS_OFS_IRQ_CTRL: st_nxt.rdata = {4'h0, st_r.src_en};
        `MMS_OFS_IRQ_STAT: st_nxt.rdata = {3'h0, st_r.nmi_pend, second_maskable_request_flags_i};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register; reset holds the latch open so the mode is caught on release
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
      st_r.in_reset <= 1'b1;
      st_r.nmi_prev <= 1'b1;
      st_r.seq <= MMS_IDLE;
      st_r.src_en <= 4'(`MMS_IRQ_CTRL_RST);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o = st_r.rdata;
  assign irq_busy_o = (st_r.seq != MMS_IDLE);
  assign stack_push_o = (st_r.seq == MMS_STACK);
  assign stack_index_o = st_r.stk;
  assign set_mask_o = (st_r.seq == MMS_FETCH);
  assign vector_load_o = st_r.vload;
  assign vector_addr_o = st_r.vec;
  assign vector_external_o = (st_r.mode == 3'd3) || (st_r.mode == 3'd2)
    || (st_r.mode == 3'd1) || (st_r.mode == 3'd0 && st_r.ext_vec_cnt != 2'd0);
endmodule : mms_core
`default_nettype wire

// ### core/mms_defines.svh
// Constants for the mode map and interrupt sequencer
`ifndef MMS_DEFINES_SVH
`define MMS_DEFINES_SVH
`define MMS_OFS_PORT_TWO_DATA 8'h03
`define MMS_OFS_DDR_THREE 8'h04
`define MMS_OFS_DDR_FOUR 8'h05
`define MMS_OFS_DATA_THREE 8'h06
`define MMS_OFS_DATA_FOUR 8'h07
`define MMS_OFS_CSR_THREE 8'h0f
`define MMS_OFS_IRQ_CTRL 8'h18
`define MMS_OFS_IRQ_STAT 8'h19
`define MMS_REG_AREA_TOP 16'h0020
`define MMS_RAM_BASE 16'h0080
`define MMS_RAM_TOP 16'h00ff
`define MMS_ROM_BASE 16'hf800
`define MMS_PAGE_BASE 16'h0100
`define MMS_PAGE_TOP 16'h01ff
`define MMS_MODE_BIT_POS 5
`define MMS_VEC_RESET 16'hfffe
`define MMS_VEC_NMI 16'hfffc
`define MMS_VEC_SWI 16'hfffa
`define MMS_VEC_FIRST_MASKABLE_REQUEST 16'hfff8
`define MMS_VEC_ICF 16'hfff6
`define MMS_VEC_OCF 16'hfff4
`define MMS_VEC_TOF 16'hfff2
`define MMS_VEC_SCI 16'hfff0
`define MMS_EXT_VEC_CYCLES 2
`define MMS_BUS_DIV 4
`define MMS_STACK_BYTES 3'd7
`define MMS_IRQ_CTRL_RST 8'h00
`endif

// ### core/mms_pkg.sv
// Types shared by the mode map and interrupt sequencer
package mms_pkg;
  typedef enum logic [1:0] {MMS_IDLE, MMS_STACK, MMS_FETCH} mms_seq_e;
  typedef enum logic [2:0] {MMS_T_NONE, MMS_T_ROM, MMS_T_RAM, MMS_T_REG, MMS_T_EXT} mms_tgt_e;
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
  } mms_cpu_s;
  typedef struct packed {
    logic capture_event_flag;
    logic compare_match_flag;
    logic counter_overflow_flag;
    logic serial_interface_unit;
  } mms_second_maskable_request_s;
endpackage : mms_pkg

// ### verification/mms_core_props.sv
// Checker for the mode map and interrupt sequencer ports
`timescale 1ns/10ps
`default_nettype none
module mms_core_props #(
  parameter int BUS_DIV = 4
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire mms_pkg::mms_cpu_s cpu_i,
  input wire logic rom_sel_o,
  input wire logic ram_sel_o,
  input wire logic reg_sel_o,
  input wire logic ext_sel_o,
  input wire logic external_page_select_o,
  input wire logic bus_phase_o,
  input wire logic address_latch_strobe_o,
  input wire logic [7:0] port_four_out_o,
  input wire logic [7:0] port_four_oe_o,
  input wire mms_pkg::mms_second_maskable_request_s second_maskable_request_flags_i,
  input wire logic instr_done_i,
  input wire logic second_maskable_request_o,
  input wire logic stack_push_o,
  input wire logic [2:0] stack_index_o,
  input wire logic set_mask_o,
  input wire logic vector_load_o
);
  import mms_pkg::*;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Decode and port four relations
  sel_onehot_a: assert property ($onehot0({rom_sel_o, ram_sel_o, reg_sel_o, ext_sel_o}))
    else $error("more than one access target selected");
  reg_area_a: assert property (reg_sel_o |-> cpu_i.addr < 16'h0020)
    else $error("register target outside the low 32 addresses");
  page_sel_a: assert property (external_page_select_o |-> cpu_i.addr[15:8] == 8'h01)
    else $error("page select outside 0100 to 01ff");
  p4_ones_a: assert property ((port_four_out_o | port_four_oe_o) == 8'hff)
    else $error("port four input line not driven high");
  second_maskable_request_or_a: assert property (second_maskable_request_o |-> |second_maskable_request_flags_i)
    else $error("second line raised with no flag");
  // Interrupt sequence shape: seven pushes, mask, then vector load
  push_cause_a: assert property ($rose(stack_push_o) |-> $past(instr_done_i))
    else $error("stacking began away from an instruction end");
  stack_idx_a: assert property ($rose(stack_push_o) |-> stack_index_o == 3'd0)
    else $error("stacking did not start at index zero");
  stack_seq_a: assert property ($rose(stack_push_o) |-> stack_push_o [*7]
    ##1 (!stack_push_o && set_mask_o) ##1 vector_load_o)
    else $error("stack, mask and vector order broken");
  phase_a: assert property ($rose(bus_phase_o) |=> bus_phase_o ##1 !bus_phase_o [*2]
    ##1 bus_phase_o)
    else $error("bus phase not a divide by four");
  strobe_low_a: assert property (address_latch_strobe_o |-> !bus_phase_o)
    else $error("address strobe during bus phase high");
  c_irq: cover property ($rose(stack_push_o));
  c_page: cover property (external_page_select_o);
  c_vec: cover property (vector_load_o);
endmodule : mms_core_props
bind mms_core mms_core_props #(.BUS_DIV(BUS_DIV)) u_props (.ref_clk_i, .reset_n_i, .cpu_i,
  .rom_sel_o, .ram_sel_o, .reg_sel_o, .ext_sel_o, .external_page_select_o, .bus_phase_o,
  .address_latch_strobe_o,
  .port_four_out_o, .port_four_oe_o, .second_maskable_request_flags_i, .instr_done_i,
  .second_maskable_request_o, .stack_push_o, .stack_index_o, .set_mask_o, .vector_load_o);
`default_nettype wire

// ### verification/mms_ext_mem.sv
// External memory on the expansion bus
`timescale 1ns/10ps
`default_nettype none
module mms_ext_mem (
  input wire logic clk_i,
  input wire logic sel_i,
  input wire logic phase_i,
  input wire logic [15:0] addr_i,
  output logic en_o,
  output logic [7:0] data_o
);
  logic [7:0] last_r = 8'h00;
  // Enabled only in the high phase so the address phase is never fought
  assign en_o = sel_i & phase_i;
  // Released bus shows the inverse of the last byte, not a stale copy
  assign data_o = en_o ? (addr_i[7:0] ^ 8'h5a) : ~last_r;
  always_ff @(posedge clk_i) begin
    if (en_o) last_r <= addr_i[7:0] ^ 8'h5a;
  end
endmodule : mms_ext_mem
`default_nettype wire

// ### verification/mms_core_tb.sv
// Self-checking bench for the mode map and interrupt sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module mms_core_tb;
  import mms_pkg::*;
  logic clk = 0, rst_n = 0, nmi_n = 1, first_maskable_request_n = 1, is3 = 0, software_trap = 0, done = 0, mask = 0;
  logic wr_s = 0, rd_s = 0, pgs, mux, ph, vl, ve, busy, second_maskable_request, esel, mem_en;
  logic [2:0] mp = 0;
  logic [7:0] ra = 0, wd = 0, rdata, p4o, p4e, mem_d;
  logic [15:0] va;
  mms_cpu_s cpu = '0;
  mms_second_maskable_request_s f2 = '0;
  mms_tgt_e tgt;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  always #4 clk = ~clk;
  mms_core dut_u (.ref_clk_i(clk), .reset_n_i(rst_n), .mode_pin_low_i(mp[0]),
    .mode_pin_mid_i(mp[1]), .mode_pin_high_i(mp[2]), .port_two_pins_i(5'h15),
    .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .cpu_i(cpu), .cpu_addr_out_i(16'h1234), .target_o(tgt), .external_page_select_o(pgs),
    .rom_sel_o(), .ram_sel_o(), .reg_sel_o(), .ext_sel_o(esel), .mux_bus_o(mux),
    .bus_phase_o(ph), .address_latch_strobe_o(), .port_four_out_o(p4o),
    .port_four_oe_o(p4e), .nmi_n_i(nmi_n), .first_maskable_request_n_i(first_maskable_request_n),
    .port_three_input_strobe_flag_i(is3), .second_maskable_request_flags_i(f2), .software_trap_i(software_trap),
    .instr_done_i(done), .mask_bit_i(mask), .second_maskable_request_o(second_maskable_request),
    .irq_busy_o(busy), .stack_push_o(), .stack_index_o(), .set_mask_o(),
    .vector_load_o(vl), .vector_addr_o(va), .vector_external_o(ve));
  mms_ext_mem mem_u (.clk_i(clk), .sel_i(esel), .phase_i(ph), .addr_i(cpu.addr),
    .en_o(mem_en), .data_o(mem_d));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // Hang guard well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin ra <= a; wd <= d; wr_s <= 1; end
    @(posedge clk) wr_s <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk) begin ra <= a; rd_s <= 1; end
    @(posedge clk) rd_s <= 0;
    @(negedge clk) v = rdata;
  endtask : rd
  // Reset held twelve clocks, three bus cycles; straps stay put afterwards
  task automatic rst(input logic [2:0] m);
    @(posedge clk) begin rst_n <= 0; mp <= m; end
    repeat (12) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
  endtask : rst
  task automatic dec(input logic [15:0] a, input mms_tgt_e e);
    @(posedge clk) cpu <= '{addr: a, rd: 1'b1, wr: 1'b0};
    @(negedge clk) `CHK("target", e, tgt)
  endtask : dec
  task automatic t_modes();
    logic [7:0] v;
    for (int m = 0; m < 8; m++) begin
      rst(3'(m));
      @(negedge clk) `CHK("reset vector", 16'hfffe, va)
      `CHK("vector ext early", m < 4, ve)
      if (m == 0) dec(16'hfffe, MMS_T_EXT);
      repeat (10) @(negedge clk);
      `CHK("vector ext late", m inside {[1:3]}, ve)
      if (m == 0) dec(16'hfffe, MMS_T_ROM);
      rd(8'h03, v);
      `CHK("mode readback", {3'(m), 5'h15}, v)
      `CHK("mux bus", m inside {[0:3], 6}, mux)
      dec(16'h0006, m == 5 ? MMS_T_NONE : m inside {4, 7} ? MMS_T_REG : MMS_T_EXT);
      dec(16'h0007, m < 4 ? MMS_T_EXT : MMS_T_REG);
      dec(16'h0011, MMS_T_REG);
      if (m == 3) dec(16'hf800, MMS_T_EXT);
      if (m == 4) dec(16'h12a0, MMS_T_RAM);
      if (m == 4) dec(16'hf800, MMS_T_NONE);
    end
  endtask : t_modes
  task automatic t_p4();
    logic [7:0] v;
    rst(3'd6);
    wr(8'h05, 8'hf0);
    @(negedge clk) `CHK("port four m6", 8'h1f, p4o)
    `CHK("port four oe m6", 8'hf0, p4e)
    rst(3'd4);
    wr(8'h03, 8'h20);
    rd(8'h03, v);
    `CHK("mode switch", 3'd5, v[7:5])
    `CHK("port four idle", 8'hff, p4o)
    wr(8'h05, 8'h0f);
    @(negedge clk) `CHK("port four m5", 8'hf4, p4o)
    dec(16'h0150, MMS_T_EXT);
    `CHK("page select", 1'b1, pgs)
    // Partner answers only in the high phase of the bus clock
    while (ph !== 1'b1) @(negedge clk);
    `CHK("mem enable", 1'b1, mem_en)
    `CHK("mem data", 8'h0a, mem_d)
    while (ph !== 1'b0) @(negedge clk);
    `CHK("mem idle", 1'b0, mem_en)
    dec(16'h0004, MMS_T_NONE);
    `CHK("no page select", 1'b0, pgs)
    rd(8'h1f, v);
    `CHK("reserved read", 8'h00, v)
  endtask : t_p4
  // q is {mask, nmi, swi, first line, strobe}
  task automatic irq(input logic [7:0] en, input logic [3:0] f, input logic [4:0] q,
    input logic [15:0] e);
    logic seen;
    wr(8'h18, en);
    @(posedge clk) begin f2 <= f; mask <= q[4]; nmi_n <= !q[3]; end
    software_trap <= q[2];
    first_maskable_request_n <= !q[1];
    is3 <= q[0];
    @(negedge clk) `CHK("second line", |(f & en[3:0]), second_maskable_request)
    @(posedge clk) done <= 1;
    @(posedge clk) done <= 0;
    @(negedge clk) `CHK("busy", !(q[4] && !q[3]), busy)
    for (int n = 0; n < 20 && vl !== 1'b1; n++) @(negedge clk);
    seen = (vl === 1'b1);
    @(negedge clk);
    if (q[4] && !q[3]) `CHK("masked", 1'b0, seen)
    `CHK("vector", e, va)
    @(posedge clk) begin f2 <= '0; mask <= 0; nmi_n <= 1; end
    software_trap <= 0;
    first_maskable_request_n <= 1;
    is3 <= 0;
    repeat (4) @(posedge clk);
  endtask : irq
  task automatic t_irq();
    rst(3'd7);
    irq(8'h0f, 4'b1001, 5'b00000, 16'hfff6);
    irq(8'h01, 4'b0101, 5'b00000, 16'hfff0);
    irq(8'h0f, 4'b0010, 5'b00010, 16'hfff8);
    irq(8'h0f, 4'b0000, 5'b00001, 16'hfff8);
    irq(8'h0f, 4'b0000, 5'b00110, 16'hfffa);
    irq(8'h0f, 4'b1111, 5'b11000, 16'hfffc);
    irq(8'h0f, 4'b0010, 5'b10010, 16'hfffc);
  endtask : t_irq
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    t_modes();
    t_p4();
    t_irq();
    wrap_up();
  end
endmodule : mms_core_tb
`default_nettype wire
